// *** core/lcf_pkg.sv ***
// Shared constants and types for the load-control frame link.
// Assumes both ends run on one clock with an active-low async reset.
package lcf_pkg;
  localparam logic [7:0]  DELIM       = 8'h7E;
  localparam logic [7:0]  FT_AUTH     = 8'hA2;
  localparam logic [7:0]  FT_EXPL     = 8'h11;
  localparam logic [7:0]  CSUM_BASE   = 8'hFF;
  localparam int          CSUM_FIRST  = 3;
  localparam logic [15:0] AUTH_LEN    = 16'h000C;
  localparam int          AUTH_LAST   = 15;
  localparam logic [15:0] EV_LEN      = 16'h002E;
  localparam int          EV_LAST     = 49;
  localparam int          BUF_DEPTH   = 64;
  localparam logic [7:0]  FRAME_ID    = 8'h01;
  localparam logic [7:0]  SRC_EP      = 8'h41;
  localparam logic [7:0]  DST_EP      = 8'h42;
  localparam logic [15:0] CLUSTER_ID  = 16'h0701;
  localparam logic [15:0] PROFILE_ID  = 16'h0109;
  localparam logic [7:0]  CMD_EVENT   = 8'h00;
  localparam logic [7:0]  STATUS_OK   = 8'h00;
  // Frame control field layout.
  localparam logic [1:0]  FC_TYPE_CLS = 2'h1;
  localparam int          FC_MFR_BIT  = 2;
  localparam int          FC_DIR_BIT  = 3;
  localparam int          FC_DDR_BIT  = 4;
  // Byte offsets inside the authentication frame (ADDR, NWK, STAT) and the event frame.
  localparam int OFF_ADDR   = 4;
  localparam int OFF_NWK    = 12;
  localparam int OFF_STAT   = 14;
  localparam int OFF_FC     = 23;
  localparam int OFF_SEQ    = 24;
  localparam int OFF_EVID   = 26;
  localparam int OFF_CLASS  = 30;
  localparam int OFF_GROUP  = 32;
  localparam int OFF_START  = 33;
  localparam int OFF_DUR    = 37;
  localparam int OFF_CRIT   = 39;
  localparam int OFF_COFS   = 40;
  localparam int OFF_HOFS   = 41;
  localparam int OFF_CSP    = 42;
  localparam int OFF_HSP    = 44;
  localparam int OFF_ADJ    = 46;
  localparam int OFF_DUTY   = 47;
  localparam int OFF_OPT    = 48;
  // Not-used sentinels and reset values.
  localparam logic [7:0]  OFS_UNUSED  = 8'hFF;
  localparam logic [15:0] SP_UNUSED   = 16'h8000;
  localparam logic [7:0]  ADJ_UNUSED  = 8'h80;
  localparam logic [7:0]  DUTY_UNUSED = 8'hFF;
  localparam logic [7:0]  GROUP_ALL   = 8'h00;
  localparam logic [31:0] START_NOW   = 32'h00000000;
  localparam logic [15:0] NWK_UNKNOWN = 16'hFFFE;
  // Host register word indices.
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h1;
  localparam logic [3:0] REG_EVID  = 4'h2;
  localparam logic [3:0] REG_CLS   = 4'h3;
  localparam logic [3:0] REG_START = 4'h4;
  localparam logic [3:0] REG_DUR   = 4'h5;
  localparam logic [3:0] REG_SP    = 4'h6;
  localparam logic [3:0] REG_LIM   = 4'h7;
  localparam logic [3:0] REG_DSTL  = 4'h8;
  localparam logic [3:0] REG_DSTH  = 4'h9;
  localparam logic [3:0] REG_DST16 = 4'hA;
  localparam logic [3:0] REG_AUTHL = 4'hB;
  localparam logic [3:0] REG_AUTHH = 4'hC;
  localparam logic [3:0] REG_AUTH16 = 4'hD;
  localparam int          CFG_FIRST = 2;
  localparam int          CFG_LAST  = 10;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b000,
    RX_LENH = 3'b001,
    RX_LENL = 3'b010,
    RX_BODY = 3'b011,
    RX_CSUM = 3'b100
  } lcf_rx_e;

  function automatic logic [31:0] cfg_rst(input int i);
    case (i)
      5:       cfg_rst = {OFS_UNUSED, OFS_UNUSED, 16'h0000};
      6:       cfg_rst = {SP_UNUSED, SP_UNUSED};
      7:       cfg_rst = {8'h00, 8'h00, DUTY_UNUSED, ADJ_UNUSED};
      10:      cfg_rst = {16'h0000, NWK_UNKNOWN};
      default: cfg_rst = 32'h00000000;
    endcase
  endfunction
endpackage

// *** core/lcf_link_if.sv ***
// Byte-stream link between the host end and the device end.
// Assumes both ends share one clock; no clocking block is used.
interface lcf_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;

  modport host (
    output h2d_data,
    output h2d_valid,
    input  h2d_ready,
    input  d2h_data,
    input  d2h_valid,
    output d2h_ready
  );

  modport dev (
    input  h2d_data,
    input  h2d_valid,
    output h2d_ready,
    output d2h_data,
    output d2h_valid,
    input  d2h_ready
  );
endinterface

// *** core/lcf_dev_end.sv ***
// Device end: parses host event frames and sends authentication frames.
// Assumes the host end shares clk_in and obeys valid/ready on the link.
module lcf_dev_end (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  lcf_link_if.dev          link,
  input  wire logic        auth_req_in,
  input  wire logic [63:0] auth_addr_in,
  input  wire logic [15:0] auth_nwk_in,
  output logic             auth_busy_out,
  output logic             ev_valid_out,
  output logic             err_out,
  output logic [7:0]       ev_fc_out,
  output logic [31:0]      ev_id_out,
  output logic [15:0]      ev_class_out,
  output logic [7:0]       ev_group_out,
  output logic [31:0]      ev_start_out,
  output logic [15:0]      ev_dur_out,
  output logic [7:0]       ev_crit_out,
  output logic [7:0]       ev_cofs_out,
  output logic [7:0]       ev_hofs_out,
  output logic [15:0]      ev_csp_out,
  output logic [15:0]      ev_hsp_out,
  output logic [7:0]       ev_adj_out,
  output logic [7:0]       ev_duty_out,
  output logic [7:0]       ev_opt_out
);
  lcf_pkg::lcf_rx_e rx_q;
  logic [7:0]  buf_q [lcf_pkg::BUF_DEPTH];
  logic [15:0] len_q;
  logic [15:0] cnt_q;
  logic [7:0]  sum_q;
  logic        ok_q;
  logic        rdy_q;
  logic        take;
  logic [7:0]  rb;
  logic [5:0]  tidx_q;
  logic [7:0]  tsum_q;
  logic [63:0] addr_q;
  logic [15:0] nwk_q;
  logic [7:0]  tdata_q;
  logic        tvalid_q;
  logic        slot;
  logic [7:0]  tbyte;

  assign take = link.h2d_valid && rdy_q;
  assign rb   = link.h2d_data;
  assign link.h2d_ready = rdy_q;
  assign link.d2h_data  = tdata_q;
  assign link.d2h_valid = tvalid_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= 1'b1;
    end
  end

  // Frame parser on the host-to-device stream.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_q  <= lcf_pkg::RX_HUNT;
      len_q <= 16'h0000;
      cnt_q <= 16'h0000;
      sum_q <= 8'h00;
      ok_q  <= 1'b0;
      err_out <= 1'b0;
    end else begin
      ok_q    <= 1'b0;
      err_out <= 1'b0;
      if (take) begin
        case (rx_q)
          lcf_pkg::RX_HUNT: begin
            if (rb == lcf_pkg::DELIM) begin
              rx_q <= lcf_pkg::RX_LENH; // R20
            end
          end
          lcf_pkg::RX_LENH: begin
            len_q[15:8] <= rb; // R20
            rx_q <= lcf_pkg::RX_LENL;
          end
          lcf_pkg::RX_LENL: begin
            len_q[7:0] <= rb;
            cnt_q <= 16'h0000;
            sum_q <= 8'h00;
            rx_q <= ({len_q[15:8], rb} == 16'h0000) ? lcf_pkg::RX_HUNT
                                                    : lcf_pkg::RX_BODY;
          end
          lcf_pkg::RX_BODY: begin
            if (cnt_q < 16'(lcf_pkg::BUF_DEPTH - lcf_pkg::CSUM_FIRST)) begin
              buf_q[6'(cnt_q + 16'(lcf_pkg::CSUM_FIRST))] <= rb;
            end
            sum_q <= sum_q + rb;
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q + 16'h0001 == len_q) begin
              rx_q <= lcf_pkg::RX_CSUM;
            end
          end
          lcf_pkg::RX_CSUM: begin
            ok_q    <= (rb == lcf_pkg::CSUM_BASE - sum_q); // R1
            err_out <= (rb != lcf_pkg::CSUM_BASE - sum_q); // R20
            rx_q    <= lcf_pkg::RX_HUNT;
          end
          default: rx_q <= lcf_pkg::RX_HUNT;
        endcase
      end
    end
  end

  // Event fields are published only from frames that passed the check.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ev_valid_out <= 1'b0;
      ev_fc_out    <= 8'h00;
      ev_id_out    <= 32'h00000000;
      ev_class_out <= 16'h0000;
      ev_group_out <= 8'h00;
      ev_start_out <= 32'h00000000;
      ev_dur_out   <= 16'h0000;
      ev_crit_out  <= 8'h00;
      ev_cofs_out  <= 8'h00;
      ev_hofs_out  <= 8'h00;
      ev_csp_out   <= 16'h0000;
      ev_hsp_out   <= 16'h0000;
      ev_adj_out   <= 8'h00;
      ev_duty_out  <= 8'h00;
      ev_opt_out   <= 8'h00;
    end else begin
      ev_valid_out <= 1'b0;
      if (ok_q && len_q == lcf_pkg::EV_LEN &&
          buf_q[lcf_pkg::CSUM_FIRST] == lcf_pkg::FT_EXPL) begin // R20
        ev_valid_out <= 1'b1;
        ev_fc_out    <= buf_q[lcf_pkg::OFF_FC];
        ev_id_out    <= {buf_q[lcf_pkg::OFF_EVID + 3],
                         buf_q[lcf_pkg::OFF_EVID + 2],
                         buf_q[lcf_pkg::OFF_EVID + 1],
                         buf_q[lcf_pkg::OFF_EVID]};
        ev_class_out <= {buf_q[lcf_pkg::OFF_CLASS + 1],
                         buf_q[lcf_pkg::OFF_CLASS]};
        ev_group_out <= buf_q[lcf_pkg::OFF_GROUP];
        ev_start_out <= {buf_q[lcf_pkg::OFF_START + 3],
                         buf_q[lcf_pkg::OFF_START + 2],
                         buf_q[lcf_pkg::OFF_START + 1],
                         buf_q[lcf_pkg::OFF_START]};
        ev_dur_out   <= {buf_q[lcf_pkg::OFF_DUR + 1],
                         buf_q[lcf_pkg::OFF_DUR]};
        ev_crit_out  <= buf_q[lcf_pkg::OFF_CRIT];
        ev_cofs_out  <= buf_q[lcf_pkg::OFF_COFS];
        ev_hofs_out  <= buf_q[lcf_pkg::OFF_HOFS];
        ev_csp_out   <= {buf_q[lcf_pkg::OFF_CSP + 1],
                         buf_q[lcf_pkg::OFF_CSP]};
        ev_hsp_out   <= {buf_q[lcf_pkg::OFF_HSP + 1],
                         buf_q[lcf_pkg::OFF_HSP]};
        ev_adj_out   <= buf_q[lcf_pkg::OFF_ADJ];
        ev_duty_out  <= buf_q[lcf_pkg::OFF_DUTY];
        ev_opt_out   <= buf_q[lcf_pkg::OFF_OPT];
      end
    end
  end

  // Authentication indication frame bytes.
  always_comb begin
    tbyte = 8'h00;
    case (tidx_q)
      6'd0:    tbyte = lcf_pkg::DELIM;
      6'd1:    tbyte = lcf_pkg::AUTH_LEN[15:8];
      6'd2:    tbyte = lcf_pkg::AUTH_LEN[7:0];
      6'd3:    tbyte = lcf_pkg::FT_AUTH; // R17
      6'd4, 6'd5, 6'd6, 6'd7, 6'd8, 6'd9, 6'd10, 6'd11:
        tbyte = addr_q[8 * (11 - tidx_q) +: 8]; // R17
      6'd12:   tbyte = nwk_q[15:8]; // R18
      6'd13:   tbyte = nwk_q[7:0]; // R18
      6'd14:   tbyte = lcf_pkg::STATUS_OK; // R19
      default: tbyte = lcf_pkg::CSUM_BASE - tsum_q; // R1
    endcase
  end

  assign slot = !tvalid_q || link.d2h_ready;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      auth_busy_out <= 1'b0;
      tidx_q   <= 6'd0;
      tsum_q   <= 8'h00;
      addr_q   <= 64'h0;
      nwk_q    <= 16'h0000;
      tdata_q  <= 8'h00;
      tvalid_q <= 1'b0;
    end else begin
      if (tvalid_q && link.d2h_ready) begin
        tvalid_q <= 1'b0;
      end
      if (!auth_busy_out && auth_req_in) begin
        auth_busy_out <= 1'b1;
        addr_q <= auth_addr_in;
        nwk_q  <= auth_nwk_in;
        tidx_q <= 6'd0;
        tsum_q <= 8'h00;
      end else if (auth_busy_out && slot) begin
        tdata_q  <= tbyte;
        tvalid_q <= 1'b1;
        if (tidx_q >= 6'(lcf_pkg::CSUM_FIRST)) begin
          tsum_q <= tsum_q + tbyte; // R1
        end
        if (tidx_q == 6'(lcf_pkg::AUTH_LAST)) begin
          auth_busy_out <= 1'b0;
        end else begin
          tidx_q <= tidx_q + 6'd1;
        end
      end
    end
  end
endmodule

// *** core/lcf_host_end.sv ***
// Host end: builds load control event frames from Avalon-MM registers
// and parses authentication frames coming back from the device.
// Assumes the device end shares clk_in and obeys valid/ready.
// Summary of operation
// R1 - Checksum is 0xFF minus byte sum from 3.
// R2 - Event identifier at 26-29, low byte first.
// R3 - Device class at 30-31, low byte first.
// R4 - Enrollment group at 32; zero means all.
// R5 - Start time at 33-36; zero means now.
// R6 - Duration minutes at 37-38, low byte first.
// R7 - Criticality level byte at offset 39.
// R8 - Temperature offsets at 40, 41; 0xFF unused.
// R9 - Set points at 42-45, LSB first; 0x8000 unused.
// R10 - Load adjustment at 46; 0x80 unused.
// R11 - Duty cycle at 47; 0xFF unused.
// R12 - Event options bitmap at 48 before checksum.
// R13 - Frame control bits 0-1 are 01.
// R14 - Control bit 2 clear omits manufacturer code.
// R15 - Control bit 3 set: server to client.
// R16 - Bit 4 clear keeps response; bits 5-7 zero.
// R17 - Authentication frame type 0xa2, address MSB first.
// R18 - Network address at 12 high, 13 low.
// R19 - Authentication status byte is always 0x00.
// R20 - Parse by delimiter and length; drop bad checksums.
module lcf_host_end (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  lcf_link_if.host         link,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out
);
  logic [31:0] cfg_q [lcf_pkg::CFG_FIRST:lcf_pkg::CFG_LAST];
  logic [7:0]  seq_q;
  logic        ddr_q;
  logic        busy_q;
  logic        new_auth_q;
  logic        rx_err_q;
  logic [7:0]  auth_st_q;
  logic [63:0] auth_addr_q;
  logic [15:0] auth_nwk_q;
  logic        wr;
  logic [31:0] rdata;

  // Avalon slave: one wait cycle, then the access completes.
  assign wr  = avs_write_in && !avs_waitrequest_out;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) &&
                               avs_waitrequest_out);
      if (avs_waitrequest_out) begin
        avs_readdata_out <= rdata;
      end
    end
  end

  always_comb begin
    rdata = 32'h00000000;
    case (avs_address_in)
      lcf_pkg::REG_CTRL:   rdata = {16'h0000, seq_q, 6'h00, ddr_q, 1'b0};
      lcf_pkg::REG_STAT:   rdata = {16'h0000, auth_st_q, 5'h00, rx_err_q,
                                    new_auth_q, busy_q};
      lcf_pkg::REG_AUTHL:  rdata = auth_addr_q[31:0];
      lcf_pkg::REG_AUTHH:  rdata = auth_addr_q[63:32];
      lcf_pkg::REG_AUTH16: rdata = {16'h0000, auth_nwk_q};
      default: begin
        if (avs_address_in >= 4'(lcf_pkg::CFG_FIRST) &&
            avs_address_in <= 4'(lcf_pkg::CFG_LAST)) begin
          rdata = cfg_q[avs_address_in];
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = lcf_pkg::CFG_FIRST; i <= lcf_pkg::CFG_LAST; i++) begin
        cfg_q[i] <= lcf_pkg::cfg_rst(i);
      end
      seq_q <= 8'h00;
      ddr_q <= 1'b0;
    end else if (wr) begin
      if (avs_address_in == lcf_pkg::REG_CTRL) begin
        seq_q <= avs_writedata_in[15:8];
        ddr_q <= avs_writedata_in[1];
      end else if (avs_address_in >= 4'(lcf_pkg::CFG_FIRST) &&
                   avs_address_in <= 4'(lcf_pkg::CFG_LAST)) begin
        cfg_q[avs_address_in] <= avs_writedata_in;
      end
    end
  end

  // Event frame transmitter.
  logic [5:0]  tidx_q;
  logic [7:0]  tsum_q;
  logic [7:0]  tdata_q;
  logic        tvalid_q;
  logic [7:0]  tbyte;
  logic [63:0] dst;
  logic [7:0]  fc;
  logic        go;

  assign dst = {cfg_q[lcf_pkg::REG_DSTH], cfg_q[lcf_pkg::REG_DSTL]};
  assign go  = wr && avs_address_in == lcf_pkg::REG_CTRL &&
               avs_writedata_in[0];
  assign link.h2d_data  = tdata_q;
  assign link.h2d_valid = tvalid_q;

  always_comb begin
    fc = 8'h00; // R16
    fc[1:0] = lcf_pkg::FC_TYPE_CLS; // R13
    fc[lcf_pkg::FC_MFR_BIT] = 1'b0; // R14
    fc[lcf_pkg::FC_DIR_BIT] = 1'b1; // R15
    fc[lcf_pkg::FC_DDR_BIT] = ddr_q; // R16
  end

  always_comb begin
    tbyte = 8'h00;
    case (tidx_q)
      6'd0:  tbyte = lcf_pkg::DELIM;
      6'd1:  tbyte = lcf_pkg::EV_LEN[15:8];
      6'd2:  tbyte = lcf_pkg::EV_LEN[7:0];
      6'd3:  tbyte = lcf_pkg::FT_EXPL;
      6'd4:  tbyte = lcf_pkg::FRAME_ID;
      6'd5, 6'd6, 6'd7, 6'd8, 6'd9, 6'd10, 6'd11, 6'd12:
        tbyte = dst[8 * (12 - tidx_q) +: 8];
      6'd13: tbyte = cfg_q[lcf_pkg::REG_DST16][15:8];
      6'd14: tbyte = cfg_q[lcf_pkg::REG_DST16][7:0];
      6'd15: tbyte = lcf_pkg::SRC_EP;
      6'd16: tbyte = lcf_pkg::DST_EP;
      6'd17: tbyte = lcf_pkg::CLUSTER_ID[15:8];
      6'd18: tbyte = lcf_pkg::CLUSTER_ID[7:0];
      6'd19: tbyte = lcf_pkg::PROFILE_ID[15:8];
      6'd20: tbyte = lcf_pkg::PROFILE_ID[7:0];
      6'd21, 6'd22: tbyte = 8'h00;
      6'd23: tbyte = fc;
      6'd24: tbyte = seq_q;
      6'd25: tbyte = lcf_pkg::CMD_EVENT;
      6'd26, 6'd27, 6'd28, 6'd29:
        tbyte = cfg_q[lcf_pkg::REG_EVID][8 * (tidx_q - 26) +: 8]; // R2
      6'd30, 6'd31:
        tbyte = cfg_q[lcf_pkg::REG_CLS][8 * (tidx_q - 30) +: 8]; // R3
      6'd32: tbyte = cfg_q[lcf_pkg::REG_CLS][23:16]; // R4
      6'd33, 6'd34, 6'd35, 6'd36:
        tbyte = cfg_q[lcf_pkg::REG_START][8 * (tidx_q - 33) +: 8]; // R5
      6'd37, 6'd38:
        tbyte = cfg_q[lcf_pkg::REG_DUR][8 * (tidx_q - 37) +: 8]; // R6
      6'd39: tbyte = cfg_q[lcf_pkg::REG_CLS][31:24]; // R7
      6'd40: tbyte = cfg_q[lcf_pkg::REG_DUR][23:16]; // R8
      6'd41: tbyte = cfg_q[lcf_pkg::REG_DUR][31:24]; // R8
      6'd42, 6'd43, 6'd44, 6'd45:
        tbyte = cfg_q[lcf_pkg::REG_SP][8 * (tidx_q - 42) +: 8]; // R9
      6'd46: tbyte = cfg_q[lcf_pkg::REG_LIM][7:0]; // R10
      6'd47: tbyte = cfg_q[lcf_pkg::REG_LIM][15:8]; // R11
      6'd48: tbyte = cfg_q[lcf_pkg::REG_LIM][23:16]; // R12
      default: tbyte = lcf_pkg::CSUM_BASE - tsum_q; // R1
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_q   <= 1'b0;
      tidx_q   <= 6'd0;
      tsum_q   <= 8'h00;
      tdata_q  <= 8'h00;
      tvalid_q <= 1'b0;
    end else begin
      if (tvalid_q && link.h2d_ready) begin
        tvalid_q <= 1'b0;
      end
      if (!busy_q && go) begin
        busy_q <= 1'b1;
        tidx_q <= 6'd0;
        tsum_q <= 8'h00;
      end else if (busy_q && (!tvalid_q || link.h2d_ready)) begin
        tdata_q  <= tbyte;
        tvalid_q <= 1'b1;
        if (tidx_q >= 6'(lcf_pkg::CSUM_FIRST)) begin
          tsum_q <= tsum_q + tbyte; // R1
        end
        if (tidx_q == 6'(lcf_pkg::EV_LAST)) begin
          busy_q <= 1'b0;
        end else begin
          tidx_q <= tidx_q + 6'd1;
        end
      end
    end
  end

  // Parser for frames from the device.
  lcf_pkg::lcf_rx_e rx_q;
  logic [7:0]  buf_q [lcf_pkg::BUF_DEPTH];
  logic [15:0] len_q;
  logic [15:0] cnt_q;
  logic [7:0]  sum_q;
  logic        ok_q;
  logic        bad_q;
  logic        rdy_q;
  logic        take;
  logic [7:0]  rb;
  logic        clr_w;

  assign take = link.d2h_valid && rdy_q;
  assign rb   = link.d2h_data;
  assign link.d2h_ready = rdy_q;
  assign clr_w = wr && avs_address_in == lcf_pkg::REG_STAT;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdy_q <= 1'b0;
      rx_q  <= lcf_pkg::RX_HUNT;
      len_q <= 16'h0000;
      cnt_q <= 16'h0000;
      sum_q <= 8'h00;
      ok_q  <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      rdy_q <= 1'b1;
      ok_q  <= 1'b0;
      bad_q <= 1'b0;
      if (take) begin
        case (rx_q)
          lcf_pkg::RX_HUNT: begin
            if (rb == lcf_pkg::DELIM) begin
              rx_q <= lcf_pkg::RX_LENH; // R20
            end
          end
          lcf_pkg::RX_LENH: begin
            len_q[15:8] <= rb; // R20
            rx_q <= lcf_pkg::RX_LENL;
          end
          lcf_pkg::RX_LENL: begin
            len_q[7:0] <= rb;
            cnt_q <= 16'h0000;
            sum_q <= 8'h00;
            rx_q <= ({len_q[15:8], rb} == 16'h0000) ? lcf_pkg::RX_HUNT
                                                    : lcf_pkg::RX_BODY;
          end
          lcf_pkg::RX_BODY: begin
            if (cnt_q < 16'(lcf_pkg::BUF_DEPTH - lcf_pkg::CSUM_FIRST)) begin
              buf_q[6'(cnt_q + 16'(lcf_pkg::CSUM_FIRST))] <= rb;
            end
            sum_q <= sum_q + rb;
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q + 16'h0001 == len_q) begin
              rx_q <= lcf_pkg::RX_CSUM;
            end
          end
          lcf_pkg::RX_CSUM: begin
            ok_q  <= (rb == lcf_pkg::CSUM_BASE - sum_q); // R1
            bad_q <= (rb != lcf_pkg::CSUM_BASE - sum_q); // R20
            rx_q  <= lcf_pkg::RX_HUNT;
          end
          default: rx_q <= lcf_pkg::RX_HUNT;
        endcase
      end
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      new_auth_q  <= 1'b0;
      rx_err_q    <= 1'b0;
      auth_st_q   <= 8'h00;
      auth_addr_q <= 64'h0;
      auth_nwk_q  <= 16'h0000;
    end else begin
      if (ok_q && len_q == lcf_pkg::AUTH_LEN &&
          buf_q[lcf_pkg::CSUM_FIRST] == lcf_pkg::FT_AUTH) begin // R17
        new_auth_q <= 1'b1;
        for (int i = 0; i < 8; i++) begin
          auth_addr_q[8 * (7 - i) +: 8] <= buf_q[lcf_pkg::OFF_ADDR + i];
        end
        auth_nwk_q <= {buf_q[lcf_pkg::OFF_NWK],
                       buf_q[lcf_pkg::OFF_NWK + 1]}; // R18
        auth_st_q  <= buf_q[lcf_pkg::OFF_STAT]; // R19
      end else if (clr_w && avs_writedata_in[1]) begin
        new_auth_q <= 1'b0;
      end
      if (bad_q) begin
        rx_err_q <= 1'b1; // R20
      end else if (clr_w && avs_writedata_in[2]) begin
        rx_err_q <= 1'b0;
      end
    end
  end
endmodule

// *** verif/lcf_asserts.sv ***
// Link checker for the load-control frame link.
// Assumes the bench instantiates it beside the link interface.
module lcf_asserts (
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic [5:0] cnt_q;
  logic [7:0] sum_q;
  wire        hx = h2d_valid && h2d_ready;
  // Offset of the host byte on the link and its running sum.
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in) cnt_q <= 6'h00;
    else if (hx && cnt_q == 6'h00)
      cnt_q <= {5'h00, h2d_data == lcf_pkg::DELIM};
    else if (hx) cnt_q <= (cnt_q == 6'h31) ? 6'h00 : cnt_q + 6'h01;
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in) sum_q <= 8'h00;
    else if (hx) sum_q <= (cnt_q < 6'h03) ? 8'h00 : sum_q + h2d_data;
  sequence s_auth_sof;
    $rose(d2h_valid) && d2h_data == lcf_pkg::DELIM;
  endsequence
  sequence s_ev_sof;
    hx && cnt_q == 6'h00 && h2d_data == lcf_pkg::DELIM;
  endsequence
  property p_rdy; $past(rstn_in) |-> h2d_ready && d2h_ready; endproperty
  property p_auth_hdr;
    s_auth_sof |=> d2h_data == 8'h00 ##1 d2h_data == 8'h0C
      ##1 d2h_data == lcf_pkg::FT_AUTH;
  endproperty
  property p_auth_stat;
    s_auth_sof |-> ##14 d2h_data == lcf_pkg::STATUS_OK;
  endproperty
  property p_auth_len;
    s_auth_sof |-> d2h_valid [*8] ##1 d2h_valid [*8] ##1 !d2h_valid;
  endproperty
  property p_ev_hdr;
    s_ev_sof |=> h2d_data == 8'h00 ##1 h2d_data == 8'h2E
      ##1 h2d_data == lcf_pkg::FT_EXPL;
  endproperty
  property p_fc_type; hx && cnt_q == 6'h17 |-> h2d_data[2:0] == 3'h1;
  endproperty
  property p_fc_dir;
    hx && cnt_q == 6'h17 |-> h2d_data[3] && h2d_data[7:5] == 3'h0;
  endproperty
  property p_ev_csum; hx && cnt_q == 6'h31 |-> h2d_data == 8'hFF - sum_q;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  a_auth_hdr: assert property (p_auth_hdr) else $error("auth head");
  a_auth_stat: assert property (p_auth_stat) else $error("status");
  a_auth_len: assert property (p_auth_len) else $error("auth len");
  a_ev_hdr: assert property (p_ev_hdr) else $error("event head");
  a_fc_type: assert property (p_fc_type) else $error("fc type");
  a_fc_dir: assert property (p_fc_dir) else $error("fc dir");
  a_ev_csum: assert property (p_ev_csum) else $error("checksum");
endmodule

// *** verif/tb_top.sv ***
// Bench for the load-control frame link with both ends joined.
// Assumes the design files and the link checker are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0, rstn_in = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        areq = 1'b0, wq, evv;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, rq, eid;
  logic [63:0] aad = 64'h0123456789ABCDEF;
  logic [15:0] anw = 16'h5A3C;
  logic [7:0]  fc, hb [64], db [16];
  int          hn, dn, err_count, samples_checked;
  always #5 clk_in = ~clk_in;
  lcf_link_if lk ();
  lcf_host_end lcf_host_end_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .link(lk), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rq), .avs_waitrequest_out(wq));
  lcf_dev_end lcf_dev_end_i (.clk_in(clk_in), .rstn_in(rstn_in), .link(lk),
    .auth_req_in(areq), .auth_addr_in(aad), .auth_nwk_in(anw),
    .auth_busy_out(), .ev_valid_out(evv), .err_out(), .ev_fc_out(fc),
    .ev_id_out(eid), .ev_class_out(), .ev_group_out(), .ev_start_out(),
    .ev_dur_out(), .ev_crit_out(), .ev_cofs_out(), .ev_hofs_out(),
    .ev_csp_out(), .ev_hsp_out(), .ev_adj_out(), .ev_duty_out(),
    .ev_opt_out());
  lcf_asserts lcf_asserts_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .h2d_data(lk.h2d_data), .h2d_valid(lk.h2d_valid),
    .h2d_ready(lk.h2d_ready), .d2h_data(lk.d2h_data),
    .d2h_valid(lk.d2h_valid), .d2h_ready(lk.d2h_ready));
  always @(posedge clk_in) begin
    if (lk.h2d_valid && lk.h2d_ready) begin
      hb[hn[5:0]] <= lk.h2d_data;
      hn <= hn + 1;
    end
    if (lk.d2h_valid && lk.d2h_ready) begin
      db[dn[3:0]] <= lk.d2h_data;
      dn <= dn + 1;
    end
  end
  task chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_in); while (wq !== 1'b0);
    rdat = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task t_ev(input logic [31:0] ctl, input logic [7:0] fcx);
    logic [7:0] ex [26];
    ex = '{fcx, ctl[15:8], 8'h00, 8'h78, 8'h56, 8'h34, 8'h12, 8'h14,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h04,
      8'hFF, 8'hFF, 8'h00, 8'h80, 8'h00, 8'h80, 8'h80, 8'hFF, 8'hA5};
    hn = 0;
    av(1'b1, lcf_pkg::REG_CTRL, ctl);
    wait (evv === 1'b1);
    @(negedge clk_in);
    chk(eid, 32'h12345678);
    chk(fc, fcx);
    for (int i = 0; i < 26; i++) begin
      chk(hb[i + 23], ex[i]);
    end
    $display("event test done");
  endtask
  task t_auth;
    logic [7:0] s;
    s = 8'h00;
    dn = 0;
    @(posedge clk_in);
    areq <= 1'b1;
    @(posedge clk_in);
    areq <= 1'b0;
    wait (dn == 16);
    repeat (3) @(posedge clk_in);
    for (int i = 3; i < 15; i++) s += db[i];
    chk(db[15], 8'hFF - s);
    chk({db[3], db[4], db[5], db[6], db[7]}, {8'hA2, aad[63:32]});
    chk({db[8], db[9], db[10], db[11]}, aad[31:0]);
    chk({db[12], db[13], db[14]}, {anw, 8'h00});
    av(1'b0, lcf_pkg::REG_STAT, 32'h0);
    chk(rdat[15:0], 16'h0002);
    av(1'b0, lcf_pkg::REG_AUTHL, 32'h0);
    chk(rdat, aad[31:0]);
    av(1'b0, lcf_pkg::REG_AUTH16, 32'h0);
    chk(rdat, {16'h0000, anw});
    av(1'b1, lcf_pkg::REG_STAT, 32'h2);
    av(1'b0, lcf_pkg::REG_STAT, 32'h0);
    chk(rdat[15:0], 16'h0000);
    $display("auth test done");
  endtask
  task t_rst;
    av(1'b0, lcf_pkg::REG_SP, 32'h0);
    chk(rdat, 32'h80008000);
    av(1'b0, lcf_pkg::REG_LIM, 32'h0);
    chk(rdat, 32'h0000FF80);
    av(1'b0, 4'hF, 32'h0);
    chk(rdat, 32'h0);
    $display("reset test done");
  endtask
  task end_sim;
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_rst;
    av(1'b1, lcf_pkg::REG_EVID, 32'h12345678);
    av(1'b1, lcf_pkg::REG_CLS, 32'h04000014);
    av(1'b1, lcf_pkg::REG_DUR, 32'hFFFF0001);
    av(1'b1, lcf_pkg::REG_LIM, 32'h00A5FF80);
    t_ev(32'h00000101, 8'h09);
    t_ev(32'h00000203, 8'h19);
    t_auth;
    end_sim;
  end
endmodule
